// File: hdl/sticky_bits.sv
// A row of sticky flags that hardware sets and another party clears.
// Assumes set and clear are single-cycle strobes on the same clock.
`timescale 1ns/1ps
module sticky_bits #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Strobes.
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flag state.
  output logic [W-1:0] q
);

  // Set wins over clear so an event in the clearing cycle is kept.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule

// File: hdl/tick_divider.sv
// Divides the selected 32.768 kHz source strobe into wake ticks.
// Assumes src_tick is a one-cycle strobe per source period.
`timescale 1ns/1ps
module tick_divider
  import wake_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Source strobe, ratio code and restart.
  input wire logic src_tick,
  input wire logic [2:0] code,
  input wire logic restart,
  // Divided tick strobe.
  output logic tick
);

  logic [15:0] cnt; // Source strobes seen in the current tick.

  // A tick leaves on the source strobe that completes the ratio.
  assign tick = src_tick && (cnt >= DIV_M1[code]);

  // Counts source strobes; restart aligns a new ratio at once.
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= '0;
    end else if (src_tick) begin
      cnt <= cnt + 16'h0001;
    end
  end

endmodule

// File: hdl/wake_pkg.sv
// Shared constants and types of the wake-up timer control block.
// Assumes a 32-bit APB master and word-aligned register words.
package wake_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [9:0] IDX_TX_AMP = 10'h307;
  localparam logic [9:0] IDX_CFG_UPPER = 10'h30C;
  localparam logic [9:0] IDX_CFG_LOWER = 10'h30D;
  localparam logic [9:0] IDX_RELOAD_UPPER = 10'h30E;
  localparam logic [9:0] IDX_RELOAD_LOWER = 10'h30F;
  localparam logic [9:0] IDX_FLAG_CTRL = 10'h310;
  localparam logic [9:0] IDX_STATUS = 10'h311;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h31A;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h31B;

  // Field positions in the lower configuration byte.
  localparam int CFG_RC_ON = 6;
  localparam int CFG_XTAL_ON = 5;
  localparam int CFG_CLK_SEL = 4;
  localparam int CFG_RAM_PWR = 3;
  localparam int CFG_ARM = 0;

  // Field positions in the upper configuration byte.
  localparam int CFG_TRIM_LSB = 3;
  localparam int CFG_DIV_LSB = 0;

  // Flag control and status bit positions.
  localparam int FLAG_CLEAR = 0;
  localparam int FLAG_CAL_RUN = 1;
  localparam int ST_NOW = 0;
  localparam int ST_LATCHED = 1;
  localparam int ST_COLD = 2;

  // Interrupt status and mask bit positions.
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_W = 2;

  // Reset values.
  localparam logic [5:0] AMP_RESET = 6'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Coarse trim landmarks: highest offset, nominal, lowest offset.
  localparam logic [3:0] TRIM_HIGHEST = 4'h0;
  localparam logic [3:0] TRIM_NOMINAL = 4'hD;
  localparam logic [3:0] TRIM_LOWEST = 4'h7;

  // Wake tick division ratios minus one, indexed by divider code.
  localparam logic [15:0] DIV_M1 [8] = '{
    16'h0000, 16'h0003, 16'h0007, 16'h000F,
    16'h007F, 16'h03FF, 16'h1FFF, 16'hFFFF};

  // Committed wake unit configuration.
  typedef struct packed {
    logic [3:0] rc_coarse_trim;
    logic [2:0] wake_tick_divider;
    logic rc_osc_on;
    logic xtal32_on;
    logic wake_clock_select;
    logic retained_ram_power;
    logic wake_arm;
  } wake_cfg_s;

  localparam wake_cfg_s CFG_RESET = '0;

endpackage

// File: hdl/wake_timer_control.sv
// Wake-up timer and low-power clock control, reached over APB.
// Assumes the oscillators deliver one-cycle strobes synchronous to CLK.
`timescale 1ns/1ps
module wake_timer_control
  import wake_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Oscillator strobes and power state.
  input wire logic RC_TICK,
  input wire logic XTAL_TICK,
  input wire logic RADIO_SLEEP_STATE,
  // Controls to the analog side.
  output wake_pkg::wake_cfg_s WAKE_CFG,
  output logic [5:0] TX_AMP_LEVEL,
  output logic RC_TRIM_RUN,
  // Timer results.
  output logic TIMEOUT_NOW,
  output logic WAKE,
  output logic IRQ
);

  // Bus decode.
  logic [9:0] idx; // Word index of the current access.
  logic mapped; // The index names a register and the byte offset is aligned.
  logic wr; // A write completes at this edge.
  logic rd; // A read completes at this edge.
  logic setup; // Setup phase of any transfer.

  // Software-visible state.
  logic [5:0] amp; // Amplifier level.
  logic [7:0] cfg_pending; // Upper configuration, not yet live.
  logic [7:0] reload_pending; // Upper reload byte, not yet live.
  logic [15:0] reload; // Committed reload count.
  logic cal_run; // RC calibration enable.
  wake_cfg_s cfg; // Committed configuration.
  logic [IRQ_W-1:0] irq_mask; // Interrupt enables.

  // Timer state.
  logic running; // Selected source is powered.
  logic src_tick; // Strobe from the selected source.
  logic wake_tick; // Divided tick.
  logic [15:0] count; // Countdown value.
  logic [15:0] next_count; // Countdown value after a tick.
  logic timeout_ev; // One-cycle pulse as zero is reached.
  logic commit_reload; // Lower reload byte written.
  logic commit_cfg; // Lower configuration byte written.

  // Flags.
  logic flag_clear; // Software clear of both latched flags.
  logic timeout_latched; // Sticky timeout.
  logic cold_start_latched; // Sticky cold start.
  logic [IRQ_W-1:0] irq_set; // Interrupt events.
  logic [IRQ_W-1:0] irq_status; // Sticky interrupt status.
  logic irq_clr; // Read of the interrupt status.

  // The low address bits must be zero for a word access.
  assign idx = PADDR[11:2];
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE && mapped;
  assign rd = PSEL && PENABLE && !PWRITE && mapped;

  // Every register answers without wait states.
  assign PREADY = 1'b1;

  // Which indices exist and whether the byte offset is aligned.
  always_comb begin
    case (idx)
      IDX_TX_AMP, IDX_CFG_UPPER, IDX_CFG_LOWER,
      IDX_RELOAD_UPPER, IDX_RELOAD_LOWER, IDX_FLAG_CTRL,
      IDX_STATUS, IDX_IRQ_STATUS, IDX_IRQ_MASK: begin
        mapped = (PADDR[1:0] == 2'b00);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Unmapped or misaligned accesses are flagged in the access phase.
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Commit strobes for the paired registers, and the flag clear strobe.
  assign commit_cfg = wr && (idx == IDX_CFG_LOWER);
  assign commit_reload = wr && (idx == IDX_RELOAD_LOWER);
  assign flag_clear = wr && (idx == IDX_FLAG_CTRL) &&
                      PWDATA[FLAG_CLEAR];

  // Amplifier level; sleep wipes it, and sleep beats a write.
  always_ff @(posedge CLK) begin
    if (RST || RADIO_SLEEP_STATE) begin
      amp <= AMP_RESET;
    end else if (wr && idx == IDX_TX_AMP) begin
      amp <= PWDATA[5:0];
    end
  end
  assign TX_AMP_LEVEL = amp;

  // Upper halves wait here until the matching lower write.
  always_ff @(posedge CLK) begin
    if (RST || RADIO_SLEEP_STATE) begin
      cfg_pending <= BYTE_RESET;
      reload_pending <= BYTE_RESET;
    end else if (wr && idx == IDX_CFG_UPPER) begin
      cfg_pending <= PWDATA[7:0];
    end else if (wr && idx == IDX_RELOAD_UPPER) begin
      reload_pending <= PWDATA[7:0];
    end
  end

  // The configuration goes live as a pair on the lower write. The
  // live copy is the wake unit's own, so it survives sleep; only the
  // shadow bytes software writes are lost. Reserved bits are dropped.
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg <= CFG_RESET;
    end else if (commit_cfg) begin
      cfg.rc_coarse_trim <= cfg_pending[CFG_TRIM_LSB +: 4];
      cfg.wake_tick_divider <= cfg_pending[CFG_DIV_LSB +: 3];
      cfg.rc_osc_on <= PWDATA[CFG_RC_ON];
      cfg.xtal32_on <= PWDATA[CFG_XTAL_ON];
      cfg.wake_clock_select <= PWDATA[CFG_CLK_SEL];
      cfg.retained_ram_power <= PWDATA[CFG_RAM_PWR];
      cfg.wake_arm <= PWDATA[CFG_ARM];
    end
  end
  assign WAKE_CFG = cfg;

  // The reload count goes live, both bytes together, on the lower
  // write; a lower write alone reuses a stale upper byte.
  always_ff @(posedge CLK) begin
    if (RST) begin
      reload <= RELOAD_RESET;
    end else if (commit_reload) begin
      reload <= {reload_pending, PWDATA[7:0]};
    end
  end

  // Calibration enable; bit 0 is a strobe and is not stored.
  always_ff @(posedge CLK) begin
    if (RST || RADIO_SLEEP_STATE) begin
      cal_run <= 1'b0;
    end else if (wr && idx == IDX_FLAG_CTRL) begin
      cal_run <= PWDATA[FLAG_CAL_RUN];
    end
  end
  assign RC_TRIM_RUN = cal_run;

  // Source select: a source that is powered down gives no strobes.
  assign running = cfg.wake_clock_select ? cfg.rc_osc_on
                                         : cfg.xtal32_on;
  assign src_tick = running && (cfg.wake_clock_select ? RC_TICK
                                                      : XTAL_TICK);

  // Ratio counter; restarting it on a commit keeps the first period
  // after a new reload a full one.
  tick_divider u_div (
    .clk(CLK),
    .rst(RST),
    .src_tick(src_tick),
    .code(cfg.wake_tick_divider),
    .restart(commit_reload || commit_cfg),
    .tick(wake_tick)
  );

  // Next countdown value: reload from zero, otherwise step down.
  always_comb begin
    if (count == 16'h0000) begin
      next_count = reload;
    end else begin
      next_count = count - 16'h0001;
    end
  end

  // Countdown register, stepped only on divided ticks.
  always_ff @(posedge CLK) begin
    if (RST) begin
      count <= RELOAD_RESET;
    end else if (commit_reload) begin
      count <= {reload_pending, PWDATA[7:0]};
    end else if (wake_tick) begin
      count <= next_count;
    end
  end

  // An event marks the tick that lands the counter on zero.
  assign timeout_ev = wake_tick && !commit_reload &&
                      (next_count == 16'h0000);
  assign TIMEOUT_NOW = running && (count == 16'h0000);

  // Wake-up only leaves the block when armed.
  always_ff @(posedge CLK) begin
    if (RST) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= timeout_ev && cfg.wake_arm;
    end
  end

  // Latched timeout and cold start share the software clear. The
  // cold-start flag comes out of reset set, since reset is power-on.
  sticky_bits #(.W(2), .RESET_VAL(2'b10)) u_flags (
    .clk(CLK),
    .rst(RST),
    .set({1'b0, timeout_ev}),
    .clr({2{flag_clear}}),
    .q({cold_start_latched, timeout_latched})
  );

  // Interrupt events: every timeout, and armed wake-ups.
  assign irq_set[IRQ_TIMEOUT] = timeout_ev;
  assign irq_set[IRQ_WAKE] = timeout_ev && cfg.wake_arm;
  assign irq_clr = rd && (idx == IDX_IRQ_STATUS);

  // Read-to-clear status. Only the bits that the read returned are
  // cleared, so an event after the setup edge waits for the next read.
  sticky_bits #(.W(IRQ_W)) u_irq (
    .clk(CLK),
    .rst(RST),
    .set(irq_set),
    .clr({IRQ_W{irq_clr}} & PRDATA[IRQ_W-1:0]),
    .q(irq_status)
  );

  // Interrupt mask.
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      irq_mask <= PWDATA[IRQ_W-1:0];
    end
  end

  // The line stays high while any enabled status bit is set.
  assign IRQ = |(irq_status & irq_mask);

  // Read data is captured in the setup phase so PRDATA is a flop.
  // Write-only registers and unmapped indices read as zero.
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup) begin
      PRDATA <= 32'h0000_0000;
      case (idx)
        IDX_TX_AMP: begin
          PRDATA[5:0] <= amp;
        end
        IDX_FLAG_CTRL: begin
          PRDATA[FLAG_CAL_RUN] <= cal_run;
        end
        IDX_STATUS: begin
          PRDATA[ST_NOW] <= TIMEOUT_NOW;
          PRDATA[ST_LATCHED] <= timeout_latched;
          PRDATA[ST_COLD] <= cold_start_latched;
        end
        IDX_IRQ_STATUS: begin
          PRDATA[IRQ_W-1:0] <= irq_status;
        end
        IDX_IRQ_MASK: begin
          PRDATA[IRQ_W-1:0] <= irq_mask;
        end
        default: begin
          PRDATA <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Checks kept next to the logic they guard.
  sequence s_wr_amp;
    wr && idx == IDX_TX_AMP && !RADIO_SLEEP_STATE;
  endsequence

  sequence s_wr_reload_lower;
    commit_reload;
  endsequence

  sequence s_tick_at_zero;
    wake_tick && !commit_reload && count == 16'h0000;
  endsequence

  AST_AMP_STORE:
    assert property (@(posedge CLK) disable iff (RST)
      s_wr_amp |=> TX_AMP_LEVEL == $past(PWDATA[5:0]))
    else $error("Amplifier level not stored from six bits.");

  AST_SLEEP_WIPE:
    assert property (@(posedge CLK) disable iff (RST)
      RADIO_SLEEP_STATE |=> TX_AMP_LEVEL == AMP_RESET &&
        reload_pending == BYTE_RESET && !RC_TRIM_RUN)
    else $error("Sleep did not wipe software registers.");

  AST_UPPER_HELD:
    assert property (@(posedge CLK) disable iff (RST)
      wr && idx == IDX_RELOAD_UPPER |=> $stable(reload))
    else $error("Upper reload byte took effect early.");

  AST_RELOAD_PAIR:
    assert property (@(posedge CLK) disable iff (RST)
      s_wr_reload_lower |=> reload ==
        {$past(reload_pending), $past(PWDATA[7:0])} && count == reload)
    else $error("Reload pair not committed together.");

  AST_CFG_COMMIT:
    assert property (@(posedge CLK) disable iff (RST)
      commit_cfg |=> WAKE_CFG.wake_arm == $past(PWDATA[CFG_ARM]) &&
        WAKE_CFG.rc_osc_on == $past(PWDATA[CFG_RC_ON]) &&
        WAKE_CFG.rc_coarse_trim == $past(cfg_pending[6:3]))
    else $error("Configuration pair not committed.");

  AST_COUNT_DOWN:
    assert property (@(posedge CLK) disable iff (RST)
      wake_tick && !commit_reload && count != 16'h0000
      |=> count == $past(count) - 16'h0001)
    else $error("Counter did not step down on a tick.");

  AST_RELOAD_ZERO:
    assert property (@(posedge CLK) disable iff (RST)
      s_tick_at_zero |=> count == $past(reload))
    else $error("Counter did not reload at zero.");

  AST_EVENT_FLAGS:
    assert property (@(posedge CLK) disable iff (RST)
      timeout_ev |=> timeout_latched && count == 16'h0000 &&
        (TIMEOUT_NOW || !running))
    else $error("Timeout event did not latch.");

  AST_WAKE_ARMED:
    assert property (@(posedge CLK) disable iff (RST)
      WAKE |-> $past(timeout_ev) && $past(cfg.wake_arm))
    else $error("Wake without an armed timeout.");

  AST_FLAG_CLEAR:
    assert property (@(posedge CLK) disable iff (RST)
      flag_clear && !timeout_ev |=> !timeout_latched &&
        !cold_start_latched)
    else $error("Flag clear did not clear both flags.");

  AST_COLD_HOLD:
    assert property (@(posedge CLK) disable iff (RST)
      cold_start_latched && !flag_clear |=> cold_start_latched)
    else $error("Cold-start flag dropped without a clear.");

  AST_TICK_SOURCE:
    assert property (@(posedge CLK) disable iff (RST)
      wake_tick |-> src_tick && running)
    else $error("Wake tick without a powered source strobe.");

  AST_CAL_RUN:
    assert property (@(posedge CLK) disable iff (RST)
      wr && idx == IDX_FLAG_CTRL && !RADIO_SLEEP_STATE
      |=> RC_TRIM_RUN == $past(PWDATA[FLAG_CAL_RUN]))
    else $error("Calibration enable not stored.");

endmodule

// File: verif/wake_timer_control_tb_top.sv
// Self-checking bench for the wake-up timer control block.
// Assumes the design files under hdl/ are compiled first.
`timescale 1ns/1ps
module wake_timer_control_tb_top;
  import wake_pkg::*;

  // Stimulus and observed signals of the block.
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rc_tick, xtal_tick, sleep, trim_run, tnow, wake, irq;
  wake_cfg_s cfg;
  logic [5:0] amp;
  // Counters, last read word and its error flag.
  int miscompares, check_count, cycles, wake_cnt, n;
  logic [31:0] rd;
  logic err;

  wake_timer_control wake_timer_control_inst (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RC_TICK(rc_tick),
    .XTAL_TICK(xtal_tick), .RADIO_SLEEP_STATE(sleep), .WAKE_CFG(cfg),
    .TX_AMP_LEVEL(amp), .RC_TRIM_RUN(trim_run), .TIMEOUT_NOW(tnow),
    .WAKE(wake), .IRQ(irq));

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Wake pulses are counted so that a missing or extra one shows up.
  always @(posedge clk) begin
    cycles++;
    if (wake === 1'b1) wake_cnt++;
    // The longest scenario needs about 50000 cycles.
    if (cycles == 80000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One more edge lets registered outputs settle before callers look.
    @(posedge clk);
  endtask

  // Pulses one oscillator strobe, then lets the tick ripple through.
  task automatic strobe(input logic xt);
    @(posedge clk);
    rc_tick <= ~xt;
    xtal_tick <= xt;
    @(posedge clk);
    rc_tick <= 1'b0;
    xtal_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Counts strobes until the counter sits at zero; at least one strobe.
  task automatic to_zero(input logic xt, input int max);
    n = 0;
    do begin
      strobe(xt);
      n++;
    end while (tnow !== 1'b1 && n < max);
  endtask

  // Reset values, write-only read-back and unmapped access.
  task automatic t_reset();
    apb(0, IDX_STATUS, 8'h00);
    chk("status", rd, 32'h0000_0004);
    chk("cfg", 32'(cfg), 32'h0000_0000);
    apb(0, IDX_TX_AMP, 8'h00);
    chk("amp", rd, 32'h0000_0000);
    apb(0, IDX_CFG_UPPER, 8'h00);
    chk("wo_read", rd, 32'h0000_0000);
    apb(1, 10'h000, 8'hFF);
    chk("unmapped_err", 32'(err), 32'h0000_0001);
    chk("ready", 32'(pready), 32'h0000_0001);
    $display("test reset done");
  endtask

  // Amplifier width, calibration enable and the wipe on sleep entry.
  task automatic t_amp_sleep();
    apb(1, IDX_TX_AMP, 8'hFF);
    apb(0, IDX_TX_AMP, 8'h00);
    chk("amp_rd", rd, 32'h0000_003F);
    chk("amp_out", 32'(amp), 32'h0000_003F);
    apb(1, IDX_FLAG_CTRL, 8'h02);
    chk("cal", 32'(trim_run), 32'h0000_0001);
    apb(0, IDX_FLAG_CTRL, 8'h00);
    chk("cal_rd", rd, 32'h0000_0002);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    sleep <= 1'b0;
    apb(0, IDX_TX_AMP, 8'h00);
    chk("amp_wiped", rd, 32'h0000_0000);
    chk("cal_wiped", 32'(trim_run), 32'h0000_0000);
    $display("test amp_sleep done");
  endtask

  // Upper byte stays pending until the lower write; every field lands.
  task automatic t_cfg();
    logic [3:0] trims [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hC, 4'hD,
                              4'h7, 4'hF};
    logic [7:0] lows [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h01, 8'h79};
    logic [3:0] prev;
    prev = 4'h0;
    for (int i = 0; i < 8; i++) begin
      apb(1, IDX_CFG_UPPER, {1'b0, trims[i], 3'(i)});
      chk("trim_pending", 32'(cfg.rc_coarse_trim), 32'(prev));
      apb(1, IDX_CFG_LOWER, 8'h00);
      chk("trim", 32'(cfg.rc_coarse_trim), 32'(trims[i]));
      chk("div", 32'(cfg.wake_tick_divider), 32'(i));
      prev = trims[i];
    end
    for (int i = 0; i < 6; i++) begin
      apb(1, IDX_CFG_UPPER, 8'h00);
      apb(1, IDX_CFG_LOWER, lows[i]);
      chk("osc_on", 32'({cfg.rc_osc_on, cfg.xtal32_on}),
          32'(lows[i][6:5]));
      chk("sel_ram_arm", 32'({cfg.wake_clock_select,
          cfg.retained_ram_power, cfg.wake_arm}),
          32'({lows[i][4:3], lows[i][0]}));
    end
    $display("test cfg done");
  endtask

  // Countdown, flags, interrupt, pending reload, source and arming.
  task automatic t_timer();
    apb(1, IDX_CFG_UPPER, 8'h00);
    apb(1, IDX_CFG_LOWER, 8'h51);
    apb(1, IDX_IRQ_MASK, 8'h03);
    apb(0, IDX_IRQ_MASK, 8'h00);
    chk("mask_rd", rd, 32'h0000_0003);
    apb(1, IDX_RELOAD_UPPER, 8'h00);
    apb(1, IDX_RELOAD_LOWER, 8'h02);
    wake_cnt = 0;
    to_zero(1'b0, 10);
    chk("ticks", 32'(n), 32'h0000_0002);
    chk("wakes", 32'(wake_cnt), 32'h0000_0001);
    apb(0, IDX_STATUS, 8'h00);
    chk("status_ev", rd, 32'h0000_0007);
    chk("irq_on", 32'(irq), 32'h0000_0001);
    apb(0, IDX_IRQ_STATUS, 8'h00);
    chk("irq_st", rd, 32'h0000_0003);
    chk("irq_off", 32'(irq), 32'h0000_0000);
    apb(1, IDX_FLAG_CTRL, 8'h01);
    apb(0, IDX_STATUS, 8'h00);
    chk("cleared", rd, 32'h0000_0001);
    // A lone upper byte must not disturb the running reload of 2.
    apb(1, IDX_RELOAD_UPPER, 8'h01);
    to_zero(1'b0, 10);
    chk("reload", 32'(n), 32'h0000_0003);
    apb(1, IDX_IRQ_MASK, 8'h00);
    chk("masked", 32'(irq), 32'h0000_0000);
    // Crystal selected: RC strobes are ignored, a crystal one reloads.
    apb(1, IDX_CFG_UPPER, 8'h00);
    apb(1, IDX_CFG_LOWER, 8'h21);
    strobe(1'b0);
    chk("rc_ignored", 32'(tnow), 32'h0000_0001);
    strobe(1'b1);
    chk("xtal_tick", 32'(tnow), 32'h0000_0000);
    // Disarmed: the timeout still happens but no wake pulse.
    apb(1, IDX_CFG_UPPER, 8'h00);
    apb(1, IDX_CFG_LOWER, 8'h20);
    apb(1, IDX_RELOAD_UPPER, 8'h00);
    apb(1, IDX_RELOAD_LOWER, 8'h01);
    to_zero(1'b1, 10);
    chk("ticks_x", 32'(n), 32'h0000_0001);
    chk("no_wake", 32'(wake_cnt), 32'h0000_0002);
    $display("test timer done");
  endtask

  // Strobes per tick for divider codes 0 to 6; code 7 is too long.
  task automatic t_div();
    int ratio [7] = '{1, 4, 8, 16, 128, 1024, 8192};
    for (int c = 0; c < 7; c++) begin
      apb(1, IDX_CFG_UPPER, {5'h00, 3'(c)});
      apb(1, IDX_CFG_LOWER, 8'h50);
      apb(1, IDX_RELOAD_UPPER, 8'h00);
      apb(1, IDX_RELOAD_LOWER, 8'h01);
      to_zero(1'b0, 9000);
      chk("ratio", 32'(n), 32'(ratio[c]));
    end
    $display("test div done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence: reset for 20 cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, rc_tick, xtal_tick, sleep} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {miscompares, check_count, cycles, wake_cnt, n} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_amp_sleep();
    t_cfg();
    t_timer();
    t_div();
    report_and_stop();
  end
endmodule
